// ### src/pwm_deadtime_trigger_ctrl.sv
// shared deadtime timing and external trigger generation of a PWM timer
// assumes counter, compares, pair enables and PWM levels come from CLK logic
//
// Register access over AXI4-Lite was chosen for this implementation.
`include "pwm_dt_defs.svh"
module pwm_deadtime_trigger_ctrl
    import pwm_dt_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RSTN,
    input  wire logic [7:0]  S_AWADDR,
    input  wire logic        S_AWVALID,
    output logic             S_AWREADY,
    input  wire logic [31:0] S_WDATA,
    input  wire logic [3:0]  S_WSTRB,
    input  wire logic        S_WVALID,
    output logic             S_WREADY,
    output logic [1:0]       S_BRESP,
    output logic             S_BVALID,
    input  wire logic        S_BREADY,
    input  wire logic [7:0]  S_ARADDR,
    input  wire logic        S_ARVALID,
    output logic             S_ARREADY,
    output logic [31:0]      S_RDATA,
    output logic [1:0]       S_RRESP,
    output logic             S_RVALID,
    input  wire logic        S_RREADY,
    input  wire logic        WRITE_PROTECT_DISABLE,
    input  wire logic [3:0]  PAIR_DEADTIME_ENABLE,
    input  wire logic [15:0] COUNTER_VALUE,
    input  wire logic [15:0] INIT_VALUE,
    input  wire logic [15:0] CHAN_COMPARE [6],
    input  wire logic [7:0]  PWM_IN,
    output logic [7:0]       PWM_OUT,
    output logic             TRIGGER_OUT
);
    // ****************************************************************
    // register bus
    // ****************************************************************
    reg8_t       dt_ctrl_ff;
    reg8_t       trig_en_ff;
    logic        flag_ff;
    logic        armed_ff;
    logic        aw_got_ff;
    logic        w_got_ff;
    logic [7:0]  awaddr_ff;
    logic [31:0] wdata_ff;
    logic        wstrb0_ff;
    logic        trig_ev;
    logic        do_wr;
    logic        wr_dt;
    logic        wr_trig;
    logic        rd_hs;

    assign do_wr   = aw_got_ff && w_got_ff && !S_BVALID;
    assign wr_dt   = do_wr && wstrb0_ff && (awaddr_ff == `DT_CTRL_ADDR);
    assign wr_trig = do_wr && wstrb0_ff && (awaddr_ff == `TRIG_CS_ADDR);
    assign rd_hs   = S_ARVALID && S_ARREADY;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            S_AWREADY <= 1'b1;
            S_WREADY  <= 1'b1;
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff  <= 32'h0;
            wstrb0_ff <= 1'b0;
            S_BVALID  <= 1'b0;
            S_BRESP   <= `RESP_OKAY;
        end else begin
            if (S_AWVALID && S_AWREADY) begin
                awaddr_ff <= S_AWADDR;
                aw_got_ff <= 1'b1;
                S_AWREADY <= 1'b0;
            end
            if (S_WVALID && S_WREADY) begin
                wdata_ff  <= S_WDATA;
                wstrb0_ff <= S_WSTRB[0];
                w_got_ff  <= 1'b1;
                S_WREADY  <= 1'b0;
            end
            if (do_wr) begin
                aw_got_ff <= 1'b0;
                w_got_ff  <= 1'b0;
                S_BVALID  <= 1'b1;
                S_BRESP   <= (awaddr_ff == `DT_CTRL_ADDR || awaddr_ff == `TRIG_CS_ADDR)
                             ? `RESP_OKAY : `RESP_SLVERR;
            end else if (S_BVALID && S_BREADY) begin
                S_BVALID  <= 1'b0;
                S_AWREADY <= 1'b1;
                S_WREADY  <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            S_ARREADY <= 1'b1;
            S_RVALID  <= 1'b0;
            S_RDATA   <= 32'h0;
            S_RRESP   <= `RESP_OKAY;
        end else if (rd_hs) begin
            S_ARREADY <= 1'b0;
            S_RVALID  <= 1'b1;
            S_RRESP   <= `RESP_OKAY;
            if (S_ARADDR == `DT_CTRL_ADDR) begin
                S_RDATA <= {24'h0, dt_ctrl_ff};
            end else if (S_ARADDR == `TRIG_CS_ADDR) begin
                S_RDATA <= {24'h0, flag_ff, trig_en_ff[6:0]};
            end else begin
                S_RDATA <= 32'h0;
                S_RRESP <= `RESP_SLVERR;
            end
        end else if (S_RVALID && S_RREADY) begin
            S_RVALID  <= 1'b0;
            S_ARREADY <= 1'b1;
        end
    end

    // ****************************************************************
    // control registers
    // ****************************************************************
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            dt_ctrl_ff <= `DT_CTRL_RST;
        end else if (wr_dt && WRITE_PROTECT_DISABLE) begin
            dt_ctrl_ff <= wdata_ff[7:0];
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            trig_en_ff <= `TRIG_CS_RST;
        end else if (wr_trig) begin
            trig_en_ff <= {1'b0, wdata_ff[6:0]};
        end
    end

    // read of a set flag arms the clear; a new trigger or a write to the trigger register disarms
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            armed_ff <= 1'b0;
        end else if (trig_ev || wr_trig) begin
            armed_ff <= 1'b0;
        end else if (rd_hs && S_ARADDR == `TRIG_CS_ADDR && flag_ff) begin
            armed_ff <= 1'b1;
        end
    end

    // a trigger in the clearing cycle wins over the clear
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            flag_ff <= 1'b0;
        end else if (trig_ev) begin
            flag_ff <= 1'b1;
        end else if (wr_trig && armed_ff && !wdata_ff[`TRIG_FLAG_BIT]) begin
            flag_ff <= 1'b0;
        end
    end

    // ****************************************************************
    // trigger generation
    // ****************************************************************
    logic [6:0] hits;
    logic [6:0] hits_q_ff;
    logic [5:0] chan_en;

    // channels 5..0 from bits 3,2,1,0,5,4; channels 6 and 7 have no compare input
    assign chan_en = {trig_en_ff[3:0], trig_en_ff[5:4]};
    assign hits[6] = trig_en_ff[`INIT_TRIG_BIT] && (COUNTER_VALUE == INIT_VALUE);
    for (genvar c = 0; c < 6; c++) begin : g_hit
        assign hits[c] = chan_en[c] && (COUNTER_VALUE == CHAN_COMPARE[c]);
    end
    // each source fires once as its match begins
    assign trig_ev = |(hits & ~hits_q_ff);

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            hits_q_ff   <= 7'h00;
            TRIGGER_OUT <= 1'b0;
        end else begin
            hits_q_ff   <= hits;
            TRIGGER_OUT <= trig_ev;
        end
    end

    // ****************************************************************
    // deadtime insertion
    // ****************************************************************
    logic     [1:0] dt_prescale;
    dtcount_t       dt_count;
    prediv_t        pre_last;
    logic     [7:0] raw_q_ff;

    // one setting for every channel
    assign dt_prescale = dt_ctrl_ff[`PRESCALE_MSB:`PRESCALE_LSB];
    assign dt_count    = dt_ctrl_ff[`DTCOUNT_MSB:0];
    assign pre_last    = !dt_prescale[1] ? 4'h0 :
                         (dt_prescale[0] ? `DIV16_LAST : `DIV4_LAST);

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            raw_q_ff <= 8'h00;
        end else begin
            raw_q_ff <= PWM_IN;
        end
    end

    for (genvar n = 0; n < 8; n++) begin : g_dt
        prediv_t  pre_ff;
        dtcount_t cnt_ff;
        always_ff @(posedge CLK or negedge RSTN) begin
            if (!RSTN) begin
                pre_ff     <= 4'h0;
                cnt_ff     <= 6'h00;
                PWM_OUT[n] <= 1'b0;
            end else if (!PAIR_DEADTIME_ENABLE[n/2] || !PWM_IN[n]) begin
                pre_ff     <= 4'h0;
                cnt_ff     <= 6'h00;
                PWM_OUT[n] <= PWM_IN[n];
            end else if (!raw_q_ff[n]) begin
                pre_ff     <= 4'h0;
                cnt_ff     <= dt_count;
                PWM_OUT[n] <= (dt_count == 6'h00);
            end else if (cnt_ff != 6'h00) begin
                if (pre_ff == pre_last) begin
                    pre_ff     <= 4'h0;
                    cnt_ff     <= cnt_ff - 6'h01;
                    PWM_OUT[n] <= (cnt_ff == 6'h01);
                end else begin
                    pre_ff <= pre_ff + 4'h1;
                end
            end else begin
                PWM_OUT[n] <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    prescale_lock_a: assert property (
        (do_wr && !WRITE_PROTECT_DISABLE) |=> $stable(dt_ctrl_ff[7:6]))
        else $error("prescale changed while write protected");
    count_lock_a: assert property (
        (do_wr && !WRITE_PROTECT_DISABLE) |=> $stable(dt_ctrl_ff[5:0]))
        else $error("deadtime count changed while write protected");
    flag_set_a: assert property (
        trig_ev |=> flag_ff && TRIGGER_OUT)
        else $error("trigger did not set flag and pulse");
    clear_need_arm_a: assert property (
        (flag_ff && !armed_ff && !trig_ev) |=> flag_ff)
        else $error("flag cleared without a prior read");
    clear_done_a: assert property (
        (wr_trig && armed_ff && !wdata_ff[7] && !trig_ev) |=> !flag_ff)
        else $error("armed zero write did not clear flag");
    clear_race_a: assert property (
        (armed_ff && trig_ev) |=> !armed_ff ##0 flag_ff)
        else $error("trigger did not reset clear sequence");
    init_trig_a: assert property (
        $rose(hits[6]) |=> TRIGGER_OUT)
        else $error("init match gave no trigger");
    init_off_a: assert property (
        (!trig_en_ff[6] && hits[5:0] == 6'h00) |=> !TRIGGER_OUT)
        else $error("trigger with no enabled match");
    pair_bypass_a: assert property (
        !PAIR_DEADTIME_ENABLE[0] |=> PWM_OUT[0] == $past(PWM_IN[0]))
        else $error("deadtime applied to disabled pair");
    dt_zero_a: assert property (
        (PAIR_DEADTIME_ENABLE[0] && dt_count == 6'h00 && $rose(PWM_IN[0])) |=> PWM_OUT[0])
        else $error("zero deadtime delayed the edge");
    dt_three_a: assert property (
        (PAIR_DEADTIME_ENABLE[0] && !dt_prescale[1] && dt_count == 6'h03 && !do_wr
         && $rose(PWM_IN[0]))
        ##1 (PWM_IN[0] && $stable(dt_ctrl_ff)) [*3]
        |-> !PWM_OUT[0] ##1 PWM_OUT[0])
        else $error("deadtime of three cycles wrong");

    trig_cov_c: cover property (trig_ev ##1 flag_ff);
    clear_cov_c: cover property (armed_ff ##1 !flag_ff);
    dt_cov_c: cover property ($rose(PWM_IN[1]) && dt_count != 6'h00 && dt_prescale == 2'h3);
endmodule : pwm_deadtime_trigger_ctrl

// ### src/pwm_dt_defs.svh
// constants of the deadtime and trigger control block
// assumes AXI4-Lite byte addresses of four times the register index
`ifndef PWM_DT_DEFS_SVH
`define PWM_DT_DEFS_SVH
`define DT_CTRL_IDX      8'h22
`define TRIG_CS_IDX      8'h23
`define DT_CTRL_ADDR     8'h88
`define TRIG_CS_ADDR     8'h8C
`define DT_CTRL_RST      8'h00
`define TRIG_CS_RST      8'h00
`define PRESCALE_MSB     7
`define PRESCALE_LSB     6
`define DTCOUNT_MSB      5
`define TRIG_FLAG_BIT    7
`define INIT_TRIG_BIT    6
`define DIV4_LAST        4'h3
`define DIV16_LAST       4'hF
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// ### src/pwm_dt_pkg.sv
// types of the deadtime and trigger control block
// assumes nothing beyond the constants header
package pwm_dt_pkg;
    typedef logic [7:0]  reg8_t;
    typedef logic [15:0] count16_t;
    typedef logic [5:0]  dtcount_t;
    typedef logic [3:0]  prediv_t;
endpackage : pwm_dt_pkg

// ### testbench/trig_consumer.sv
// consumer peripheral model: counts the cycles in which a trigger is seen
// assumes the trigger output is registered on the shared system clock
module trig_consumer (
    input  wire logic CLK,
    input  wire logic RSTN,
    input  wire logic TRIG,
    output int        hits
);
    timeunit 1ns;
    timeprecision 1ns;
    // *****
    // pulse counter
    // *****
    // a pulse held too long counts more than once
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) hits <= 0;
        else if (TRIG === 1'b1) hits <= hits + 1;
    end
endmodule : trig_consumer

// ### testbench/tb.sv
// self-checking bench of the deadtime and trigger control block
// assumes the design package and constants header are compiled first
`include "pwm_dt_defs.svh"
module tb;
    import pwm_dt_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, rstn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, wpd = 0;
    logic        awrdy, wrdy, arrdy, bv, rv, trig;
    logic [7:0]  awa = 0, ara = 0, pin = 0, pout;
    logic [31:0] wd = 0, rd;
    logic [1:0]  bresp, rresp, r;
    logic [3:0]  pde = 0;
    logic [15:0] cnt = 16'hFFFF, initv = 16'h0040, cmp [6];
    int          n_errors = 0, n_tests = 0, hits;
    int          bitmap [6] = '{4, 5, 0, 1, 2, 3};
    initial foreach (cmp[i]) cmp[i] = 16'h0010 + 16'(i);
    always #10 clk = ~clk;
    pwm_deadtime_trigger_ctrl dut (.CLK(clk), .RSTN(rstn), .S_AWADDR(awa), .S_AWVALID(awv),
        .S_AWREADY(awrdy), .S_WDATA(wd), .S_WSTRB(4'hF), .S_WVALID(wv), .S_WREADY(wrdy),
        .S_BRESP(bresp), .S_BVALID(bv), .S_BREADY(br), .S_ARADDR(ara), .S_ARVALID(arv),
        .S_ARREADY(arrdy), .S_RDATA(rd), .S_RRESP(rresp), .S_RVALID(rv), .S_RREADY(rr),
        .WRITE_PROTECT_DISABLE(wpd), .PAIR_DEADTIME_ENABLE(pde), .COUNTER_VALUE(cnt),
        .INIT_VALUE(initv), .CHAN_COMPARE(cmp), .PWM_IN(pin), .PWM_OUT(pout),
        .TRIGGER_OUT(trig));
    trig_consumer peer (.CLK(clk), .RSTN(rstn), .TRIG(trig), .hits(hits));
    // *****
    // checking and bus tasks
    // *****
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        logic aw_p = 1'b1;
        logic w_p = 1'b1;
        @(posedge clk);
        awa <= a;
        wd <= {24'h000000, d};
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        while (aw_p || w_p) begin
            @(posedge clk);
            if (awrdy === 1'b1) aw_p = 1'b0;
            if (wrdy === 1'b1) w_p = 1'b0;
            awv <= aw_p;
            wv <= w_p;
        end
        do @(posedge clk); while (bv !== 1'b1);
        r = bresp;
        br <= 1'b0;
        @(posedge clk);
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do @(posedge clk); while (arrdy !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        rr <= 1'b0;
        check("read data", rd, {24'h000000, exp});
        check("read response", rresp, er);
        @(posedge clk);
    endtask : rd_reg
    // *****
    // scenarios
    // *****
    task automatic t_dead(input logic [1:0] code, input logic [5:0] count);
        int lat [8];
        int f = code[1] ? (code[0] ? 16 : 4) : 1;
        wr_reg(`DT_CTRL_ADDR, {code, count});
        pde <= 4'hD;
        pin <= 8'hFF;
        for (int n = 1; n <= 1100; n++) begin
            @(posedge clk);
            #1;
            foreach (lat[c]) if (pout[c] === 1'b1 && lat[c] == 0) lat[c] = n;
        end
        foreach (lat[c]) begin
            if (c / 2 == 1) check("bypass delay", lat[c], 1);
            else check("rise delay", lat[c], 1 + f * count);
        end
        @(posedge clk);
        pin <= 8'h00;
        @(posedge clk);
        #1;
        check("fall", pout, 8'h00);
        @(posedge clk);
    endtask : t_dead
    task automatic pulse(input logic [15:0] v);
        @(posedge clk);
        cnt <= v;
        repeat (3) @(posedge clk);
        cnt <= 16'hFFFF;
        repeat (2) @(posedge clk);
        #1;
    endtask : pulse
    task automatic t_trig(input logic [6:0] mask);
        int   h0;
        logic e;
        wr_reg(`TRIG_CS_ADDR, {1'b0, mask});
        check("write response", r, `RESP_OKAY);
        for (int p = 0; p < 7; p++) begin
            h0 = hits;
            pulse(p < 6 ? cmp[p] : initv);
            e = p < 6 ? mask[bitmap[p]] : mask[6];
            check("pulses", hits - h0, e);
        end
    endtask : t_trig
    task automatic t_flag;
        rd_reg(`TRIG_CS_ADDR, 8'hFF, `RESP_OKAY);
        pulse(cmp[0]);
        wr_reg(`TRIG_CS_ADDR, 8'h7F);
        rd_reg(`TRIG_CS_ADDR, 8'hFF, `RESP_OKAY);
        wr_reg(`TRIG_CS_ADDR, 8'h7F);
        rd_reg(`TRIG_CS_ADDR, 8'h7F, `RESP_OKAY);
        wr_reg(`TRIG_CS_ADDR, 8'hFF);
        rd_reg(`TRIG_CS_ADDR, 8'h7F, `RESP_OKAY);
    endtask : t_flag
    initial begin
        #1ms;
        n_errors++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd_reg(`DT_CTRL_ADDR, `DT_CTRL_RST, `RESP_OKAY);
        rd_reg(`TRIG_CS_ADDR, `TRIG_CS_RST, `RESP_OKAY);
        rd_reg(8'h90, 8'h00, `RESP_SLVERR);
        wr_reg(8'h90, 8'h55);
        check("unmapped write", r, `RESP_SLVERR);
        wr_reg(`DT_CTRL_ADDR, 8'hC5);
        rd_reg(`DT_CTRL_ADDR, 8'h00, `RESP_OKAY);
        wpd <= 1'b1;
        t_dead(2'b00, 6'h05);
        t_dead(2'b01, 6'h03);
        t_dead(2'b10, 6'h07);
        t_dead(2'b11, 6'h3F);
        t_dead(2'b00, 6'h00);
        wpd <= 1'b0;
        wr_reg(`DT_CTRL_ADDR, 8'hC5);
        rd_reg(`DT_CTRL_ADDR, 8'h00, `RESP_OKAY);
        for (int b = 0; b < 7; b++) t_trig(7'(1 << b));
        t_trig(7'h7F);
        t_flag();
        end_of_test();
    end
endmodule : tb
